// ### core/clcc_pkg.sv
// Functional notes
// - Counter 1 clears when captured, if enabled
// - Terminal edge captures counter 1 unless disabled
// - Software capture command always captures counters
// - Trigger terminal is edge sensitive, one capture
// - Origin return captures counter 1 when enabled
// - Ring mode wraps counter 1 at comparator 1
// - Counter 2 clears when captured, if enabled
// - Separate terminal capture control for counter 2
// - Terminal edge captures counter 2 unless disabled
package clcc_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 5;
    localparam int STRB_W = DATA_W / 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CONFIG = 5'h00;
    localparam logic [ADDR_W-1:0] OFS_COMMAND = 5'h04;
    localparam logic [ADDR_W-1:0] OFS_CTR1 = 5'h08;
    localparam logic [ADDR_W-1:0] OFS_CTR2 = 5'h0C;
    localparam logic [ADDR_W-1:0] OFS_CMP1 = 5'h10;
    localparam logic [ADDR_W-1:0] OFS_LATCH1 = 5'h14;
    localparam logic [ADDR_W-1:0] OFS_LATCH2 = 5'h18;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h1C;

    // Command codes and field values
    localparam logic [7:0] CMD_SOFT_CAPTURE = 8'h29;
    localparam logic [DATA_W-1:0] CFG_WMASK = 32'h0000_03F0;
    localparam logic [DATA_W-1:0] CFG_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CTR_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CMP_RESET = 32'h0000_0000;
    localparam logic [DATA_W-1:0] CTR_ONE = 32'h0000_0001;
    localparam int STAT_CAP1_BIT = 0;
    localparam int STAT_CAP2_BIT = 1;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Configuration word, bits 4 to 9 carry the capture controls
    typedef struct packed {
        logic [21:0] rsvd_hi;
        logic ctr2_terminal_capture_disable;
        logic ctr2_clear_on_capture;
        logic ctr1_ring_mode;
        logic ctr1_origin_capture_enable;
        logic ctr1_terminal_capture_disable;
        logic ctr1_clear_on_capture;
        logic [3:0] rsvd_lo;
    } clcc_cfg_s;

    // Count request for one counter in one cycle
    typedef struct packed {
        logic up;
        logic down;
    } clcc_step_s;

endpackage : clcc_pkg

// ### core/clcc_edge_detect.sv
`timescale 1ns/1ps
`default_nettype none
module clcc_edge_detect #(
    parameter bit ACTIVE_LOW = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic level_in,
    output logic edge_pulse
);

    logic prev_r;

    // Previous level starts idle so reset release gives no false edge
    always_ff @(posedge clk) begin
        if (reset) begin
            prev_r <= ACTIVE_LOW;
        end else begin
            prev_r <= level_in;
        end
    end

    // One pulse per transition into the active level
    assign edge_pulse = ACTIVE_LOW ? (prev_r & ~level_in) : (~prev_r & level_in);

endmodule : clcc_edge_detect
`default_nettype wire

// ### core/clcc_top.sv
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module clcc_top (
    input wire logic clk,
    input wire logic reset,
    input wire logic [clcc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [clcc_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [clcc_pkg::STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [clcc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [clcc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic latch_trigger_terminal_n,
    input wire logic origin_capture_pulse,
    input wire clcc_pkg::clcc_step_s ctr1_step,
    input wire clcc_pkg::clcc_step_s ctr2_step,
    output logic [clcc_pkg::DATA_W-1:0] first_position_counter,
    output logic [clcc_pkg::DATA_W-1:0] second_position_counter
);

    localparam int DW = clcc_pkg::DATA_W;

    // Merge a write into an old word, byte lane by byte lane
    function automatic logic [DW-1:0] apply_strb(
        input logic [DW-1:0] old_val,
        input logic [DW-1:0] new_val,
        input logic [clcc_pkg::STRB_W-1:0] strb
    );
        logic [DW-1:0] res;
        res = old_val;
        for (int i = 0; i < clcc_pkg::STRB_W; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_val[i*8 +: 8];
            end
        end
        return res;
    endfunction : apply_strb

    // One count step; in ring mode the span is 0 to the wrap value
    function automatic logic [DW-1:0] count_step(
        input logic [DW-1:0] val,
        input clcc_pkg::clcc_step_s step,
        input logic ring,
        input logic [DW-1:0] wrap
    );
        logic [DW-1:0] res;
        res = val;
        if (step.up && !step.down) begin
            res = (ring && val == wrap) ? clcc_pkg::CTR_RESET : val + clcc_pkg::CTR_ONE;
        end else if (step.down && !step.up) begin
            res = (ring && val == clcc_pkg::CTR_RESET) ? wrap : val - clcc_pkg::CTR_ONE;
        end
        return res;
    endfunction : count_step

    // Address decode shared by the read and write paths
    function automatic logic is_mapped(input logic [clcc_pkg::ADDR_W-1:0] addr);
        logic hit;
        hit = 1'b0;
        unique case (addr)
            clcc_pkg::OFS_CONFIG, clcc_pkg::OFS_COMMAND, clcc_pkg::OFS_CTR1,
            clcc_pkg::OFS_CTR2, clcc_pkg::OFS_CMP1, clcc_pkg::OFS_LATCH1,
            clcc_pkg::OFS_LATCH2, clcc_pkg::OFS_STATUS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit;
    endfunction : is_mapped

    // Register state
    clcc_pkg::clcc_cfg_s cfg_r;
    logic [DW-1:0] ctr1_r;
    logic [DW-1:0] ctr2_r;
    logic [DW-1:0] cmp1_r;
    logic [DW-1:0] latch1_r;
    logic [DW-1:0] latch2_r;
    logic [1:0] status_r;

    // Bus slave state
    logic aw_held_r;
    logic [clcc_pkg::ADDR_W-1:0] aw_addr_r;
    logic w_held_r;
    logic [DW-1:0] w_data_r;
    logic [clcc_pkg::STRB_W-1:0] w_strb_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [DW-1:0] rdata_r;

    // Decoded events
    logic wr_go;
    logic term_edge;
    logic soft_cmd;
    logic cap1;
    logic cap2;
    logic clr1;
    logic clr2;
    logic wr_ctr1;
    logic wr_ctr2;
    logic [DW-1:0] ctr1_base;
    logic [DW-1:0] ctr2_base;
    logic [DW-1:0] rd_data;

    // Terminal is active low; only its falling edge captures
    clcc_edge_detect #(
        .ACTIVE_LOW(1'b1)
    ) u_term_edge (
        .clk(clk),
        .reset(reset),
        .level_in(latch_trigger_terminal_n),
        .edge_pulse(term_edge)
    );

    // Handshake outputs; one write and one read slot each
    assign s_axi_awready = ~aw_held_r;
    assign s_axi_wready = ~w_held_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = rdata_r;
    assign first_position_counter = ctr1_r;
    assign second_position_counter = ctr2_r;

    // A write commits once address and data are both held and no response is pending
    assign wr_go = aw_held_r & w_held_r & ~bvalid_r;

    // Write address holding register
    always_ff @(posedge clk) begin
        if (reset) begin
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
        end else if (s_axi_awvalid && !aw_held_r) begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held_r <= 1'b0;
        end
    end

    // Write data holding register
    always_ff @(posedge clk) begin
        if (reset) begin
            w_held_r <= 1'b0;
            w_data_r <= '0;
            w_strb_r <= '0;
        end else if (s_axi_wvalid && !w_held_r) begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end else if (wr_go) begin
            w_held_r <= 1'b0;
        end
    end

    // Write response; unmapped offsets answer SLVERR and change nothing
    always_ff @(posedge clk) begin
        if (reset) begin
            bvalid_r <= 1'b0;
            bresp_r <= clcc_pkg::RESP_OKAY;
        end else if (wr_go) begin
            bvalid_r <= 1'b1;
            bresp_r <= is_mapped(aw_addr_r) ? clcc_pkg::RESP_OKAY : clcc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // Write strobes for the registers with side effects
    assign wr_ctr1 = wr_go && aw_addr_r == clcc_pkg::OFS_CTR1;
    assign wr_ctr2 = wr_go && aw_addr_r == clcc_pkg::OFS_CTR2;
    assign soft_cmd = wr_go && aw_addr_r == clcc_pkg::OFS_COMMAND && w_strb_r[0]
        && w_data_r[7:0] == clcc_pkg::CMD_SOFT_CAPTURE;

    // Configuration; reserved bits stay zero
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_r <= clcc_pkg::CFG_RESET;
        end else if (wr_go && aw_addr_r == clcc_pkg::OFS_CONFIG) begin
            cfg_r <= apply_strb(cfg_r, w_data_r, w_strb_r) & clcc_pkg::CFG_WMASK;
        end
    end

    // Wrap value for ring counting of counter 1
    always_ff @(posedge clk) begin
        if (reset) begin
            cmp1_r <= clcc_pkg::CMP_RESET;
        end else if (wr_go && aw_addr_r == clcc_pkg::OFS_CMP1) begin
            cmp1_r <= apply_strb(cmp1_r, w_data_r, w_strb_r);
        end
    end

    // Capture sources; the command ignores the terminal disable bits
    assign cap1 = (term_edge & ~cfg_r.ctr1_terminal_capture_disable)
        | (origin_capture_pulse & cfg_r.ctr1_origin_capture_enable)
        | soft_cmd;
    assign cap2 = (term_edge & ~cfg_r.ctr2_terminal_capture_disable)
        | soft_cmd;
    assign clr1 = cap1 & cfg_r.ctr1_clear_on_capture;
    assign clr2 = cap2 & cfg_r.ctr2_clear_on_capture;

    // Clear happens first, then this cycle's count is still applied
    assign ctr1_base = clr1 ? clcc_pkg::CTR_RESET : ctr1_r;
    assign ctr2_base = clr2 ? clcc_pkg::CTR_RESET : ctr2_r;

    // Counter 1; a host write overrides counting in that cycle
    always_ff @(posedge clk) begin
        if (reset) begin
            ctr1_r <= clcc_pkg::CTR_RESET;
        end else if (wr_ctr1) begin
            ctr1_r <= apply_strb(ctr1_r, w_data_r, w_strb_r);
        end else begin
            ctr1_r <= count_step(ctr1_base, ctr1_step, cfg_r.ctr1_ring_mode, cmp1_r);
        end
    end

    // Counter 2 always counts linearly here
    always_ff @(posedge clk) begin
        if (reset) begin
            ctr2_r <= clcc_pkg::CTR_RESET;
        end else if (wr_ctr2) begin
            ctr2_r <= apply_strb(ctr2_r, w_data_r, w_strb_r);
        end else begin
            ctr2_r <= count_step(ctr2_base, ctr2_step, 1'b0, cmp1_r);
        end
    end

    // Latches take the value before any clear or count step
    always_ff @(posedge clk) begin
        if (reset) begin
            latch1_r <= clcc_pkg::CTR_RESET;
        end else if (cap1) begin
            latch1_r <= ctr1_r;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            latch2_r <= clcc_pkg::CTR_RESET;
        end else if (cap2) begin
            latch2_r <= ctr2_r;
        end
    end

    // Capture flags, write one to clear; a new capture beats the clear
    always_ff @(posedge clk) begin
        if (reset) begin
            status_r <= '0;
        end else begin
            if (wr_go && aw_addr_r == clcc_pkg::OFS_STATUS && w_strb_r[0]) begin
                status_r <= status_r & ~w_data_r[1:0] | {cap2, cap1};
            end else begin
                status_r <= status_r | {cap2, cap1};
            end
        end
    end

    // Read mux; reserved bits and the command word read as zero
    always_comb begin
        rd_data = '0;
        unique case (s_axi_araddr)
            clcc_pkg::OFS_CONFIG: rd_data = cfg_r;
            clcc_pkg::OFS_CTR1: rd_data = ctr1_r;
            clcc_pkg::OFS_CTR2: rd_data = ctr2_r;
            clcc_pkg::OFS_CMP1: rd_data = cmp1_r;
            clcc_pkg::OFS_LATCH1: rd_data = latch1_r;
            clcc_pkg::OFS_LATCH2: rd_data = latch2_r;
            clcc_pkg::OFS_STATUS: rd_data[1:0] = status_r;
            default: rd_data = '0;
        endcase
    end

    // Read channel: data one cycle after the address is taken
    always_ff @(posedge clk) begin
        if (reset) begin
            rvalid_r <= 1'b0;
            rresp_r <= clcc_pkg::RESP_OKAY;
            rdata_r <= '0;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r <= is_mapped(s_axi_araddr) ? clcc_pkg::RESP_OKAY : clcc_pkg::RESP_SLVERR;
            rdata_r <= rd_data;
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end

endmodule : clcc_top
`default_nettype wire

// ### tb/clcc_properties.sv
`timescale 1ns/1ps
`default_nettype none
module clcc_properties (
    input wire logic clk,
    input wire logic reset,
    input wire logic s_axi_awready,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [clcc_pkg::DATA_W-1:0] s_axi_rdata,
    input wire logic latch_trigger_terminal_n,
    input wire logic origin_capture_pulse,
    input wire clcc_pkg::clcc_step_s ctr1_step,
    input wire clcc_pkg::clcc_step_s ctr2_step,
    input wire logic [clcc_pkg::DATA_W-1:0] first_position_counter,
    input wire logic [clcc_pkg::DATA_W-1:0] second_position_counter
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic term_q;
    logic [31:0] c1, c2, c2_q;
    logic nw, fall, id1, id2, st1, st2;
    // Terminal history and a linear prediction for counter 2
    always_ff @(posedge clk) begin
        term_q <= reset | latch_trigger_terminal_n;
        c2_q <= c2 + {31'h0, ctr2_step.up} - {31'h0, ctr2_step.down};
    end
    // A bus commit may overwrite a counter, so cycles holding both halves are skipped
    assign c1 = first_position_counter;
    assign c2 = second_position_counter;
    assign nw = s_axi_awready | s_axi_wready;
    assign fall = term_q & ~latch_trigger_terminal_n;
    assign id2 = nw & ~fall;
    assign id1 = id2 & ~origin_capture_pulse;
    assign st1 = ctr1_step.up ^ ctr1_step.down;
    assign st2 = ctr2_step.up ^ ctr2_step.down;
    property p_c1_hold;
        id1 && !st1 |=> c1 == $past(c1);
    endproperty
    a_c1_hold: assert property (p_c1_hold) else $error("counter 1 moved while idle");
    property p_c1_up;
        id1 && ctr1_step.up && !ctr1_step.down |-> ##1 (c1 == $past(c1) + 32'h1 || c1 == 32'h0);
    endproperty
    a_c1_up: assert property (p_c1_up) else $error("counter 1 bad up step");
    property p_c2_lin;
        id2 |=> c2 == c2_q;
    endproperty
    a_c2_lin: assert property (p_c2_lin) else $error("counter 2 bad step");
    property p_c1_cap;
        fall && nw && !origin_capture_pulse && !st1 |=> c1 == 32'h0 || $stable(c1);
    endproperty
    a_c1_cap: assert property (p_c1_cap) else $error("counter 1 bad after capture");
    property p_c2_cap;
        fall && nw && !st2 |=> c2 == 32'h0 || $stable(c2);
    endproperty
    a_c2_cap: assert property (p_c2_cap) else $error("counter 2 bad after capture");
    property p_org;
        origin_capture_pulse && id2 && !st1 |=> c1 == 32'h0 || $stable(c1);
    endproperty
    a_org: assert property (p_org) else $error("counter 1 bad after origin");
    property p_b_after;
        !s_axi_awready && !s_axi_wready && !s_axi_bvalid |=> s_axi_bvalid;
    endproperty
    a_b_after: assert property (p_b_after) else $error("write answer late");
    property p_r_keep;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_keep: assert property (p_r_keep) else $error("read answer dropped");
    property p_r_after;
        s_axi_arvalid && s_axi_arready |-> ##1 s_axi_rvalid;
    endproperty
    a_r_after: assert property (p_r_after) else $error("read answer late");
endmodule : clcc_properties
`default_nettype wire

// ### tb/clcc_trigger_model.sv
`timescale 1ns/1ps
`default_nettype none
module clcc_trigger_model #(
    parameter int LOW = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic fire,
    output logic term_n
);
    int cnt_r;
    // Long low stretch: a level-sensitive capture would show as repeats
    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_r <= 0;
        end else if (fire) begin
            cnt_r <= LOW;
        end else if (cnt_r > 0) begin
            cnt_r <= cnt_r - 1;
        end
    end
    // Idle high from time zero, two-state counter needs no reset to settle
    assign term_n = (cnt_r == 0);
endmodule : clcc_trigger_model
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic [4:0] s_axi_awaddr = 5'h00;
    logic [4:0] s_axi_araddr = 5'h00;
    logic [2:0] s_axi_awprot = 3'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, first_position_counter, second_position_counter;
    logic latch_trigger_terminal_n;
    logic origin_capture_pulse = 1'b0;
    clcc_pkg::clcc_step_s ctr1_step = 2'h0;
    clcc_pkg::clcc_step_s ctr2_step = 2'h0;
    logic fire = 1'b0;
    int miscompares = 0;
    int checked = 0;
    logic [1:0] last_rresp = 2'h0;
    clcc_top i_dut (.*);
    clcc_trigger_model i_trig (.clk(clk), .reset(reset), .fire(fire), .term_n(latch_trigger_terminal_n));
    // 100 ns period
    always #50 clk = ~clk;
    // Watchdog against a hang anywhere
    initial begin
        #6000000;
        miscompares++;
        close_out();
    end
    task automatic close_out;
        $display("checked=%0d miscompares=%0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic guard(input int n);
        if (n >= 40) begin
            miscompares++;
            close_out();
        end
    endtask : guard
    // Address and data offered together, each dropped once taken
    task automatic wr(input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'b0;
        guard(n);
        chk({30'h0, s_axi_bresp}, 32'h0);
    endtask : wr
    task automatic rd(input logic [4:0] a, output logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        // Ready comes one cycle late, so the slave must hold its answer
        do begin
            @(posedge clk);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (n == 2) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready) && n < 40);
        d = s_axi_rdata;
        last_rresp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        guard(n);
    endtask : rd
    task automatic rc(input logic [4:0] a, input logic [31:0] e);
        logic [31:0] d;
        rd(a, d);
        chk(d, e);
        chk({30'h0, last_rresp}, 32'h0);
    endtask : rc
    task automatic trig;
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        repeat (12) @(posedge clk);
    endtask : trig
    task automatic step1(input logic [1:0] s, input int k);
        ctr1_step <= s;
        repeat (k) @(posedge clk);
        ctr1_step <= 2'h0;
        @(posedge clk);
    endtask : step1
    // Bits: clr1, dis1, org1, ring1, clr2, dis2 from bit 4 up
    function automatic logic [31:0] cfg(input logic [5:0] b);
        return {22'h0, b, 4'h0};
    endfunction : cfg
    function automatic logic [31:0] after(input logic [31:0] v, input logic hit, input logic clr);
        return (hit && clr) ? 32'h0 : v;
    endfunction : after
    // Main sequence
    initial begin
        logic [31:0] v1, v2, l1, l2;
        logic [5:0] b;
        logic [1:0] s1, s2;
        v1 = $urandom(29685);
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rc(5'h00, 32'h0);
        for (int i = 0; i < 8; i++) begin
            b = {i[1], 1'($urandom), 2'h0, i[0], i[2]};
            v1 = $urandom;
            v2 = $urandom;
            wr(5'h00, cfg(b));
            wr(5'h08, v1);
            wr(5'h0C, v2);
            rd(5'h14, l1);
            rd(5'h18, l2);
            trig();
            rc(5'h14, b[1] ? l1 : v1);
            rc(5'h18, b[5] ? l2 : v2);
            chk(first_position_counter, after(v1, !b[1], b[0]));
            chk(second_position_counter, after(v2, !b[5], b[4]));
        end
        v1 = $urandom;
        wr(5'h00, cfg(6'h01));
        wr(5'h08, v1);
        fire <= 1'b1;
        @(posedge clk);
        fire <= 1'b0;
        step1(2'h2, 3);
        repeat (10) @(posedge clk);
        rc(5'h14, v1);
        chk(first_position_counter, 32'h3);
        for (int k = 0; k < 2; k++) begin
            v1 = $urandom;
            wr(5'h00, cfg({3'h0, k[0], 2'h3}));
            wr(5'h08, v1);
            rd(5'h14, l1);
            origin_capture_pulse <= 1'b1;
            @(posedge clk);
            origin_capture_pulse <= 1'b0;
            rc(5'h14, k[0] ? v1 : l1);
            chk(first_position_counter, after(v1, k[0], 1'b1));
        end
        v1 = $urandom;
        v2 = $urandom;
        wr(5'h00, cfg(6'h22));
        wr(5'h08, v1);
        wr(5'h0C, v2);
        trig();
        wr(5'h04, 32'h29);
        rc(5'h14, v1);
        rc(5'h18, v2);
        rc(5'h1C, 32'h3);
        wr(5'h1C, 32'h3);
        rc(5'h1C, 32'h0);
        // Unaligned offset: error answer and zero data
        rd(5'h02, l1);
        chk({30'h0, last_rresp}, 32'h2);
        chk(l1, 32'h0);
        wr(5'h10, 32'h3);
        wr(5'h00, cfg(6'h08));
        wr(5'h08, 32'h2);
        step1(2'h2, 3);
        chk(first_position_counter, 32'h1);
        step1(2'h1, 2);
        chk(first_position_counter, 32'h3);
        wr(5'h0C, 32'h0);
        v2 = 32'h0;
        repeat (200) begin
            @(posedge clk);
            s1 = 2'($urandom);
            s2 = 2'($urandom);
            ctr1_step <= s1;
            ctr2_step <= s2;
            v2 = v2 + {31'h0, s2[1]} - {31'h0, s2[0]};
        end
        @(posedge clk);
        ctr1_step <= 2'h0;
        ctr2_step <= 2'h0;
        @(posedge clk);
        chk(second_position_counter, v2);
        close_out();
    end
endmodule : tb_top
bind clcc_top clcc_properties i_props (.*);
`default_nettype wire
